/* File: include/ccm_pkg.sv */
package ccm_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] PROCESSOR_CLOCK_CTRL_OFF = 8'h00;
  localparam logic [7:0] MAIN_CLOCK_MODE_REG_OFF  = 8'h04;
  localparam logic [7:0] MAIN_OSC_CTRL_OFF        = 8'h08;
  localparam logic [7:0] RING_OSC_MODE_REG_OFF    = 8'h0C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SUBSYS_HALT_BIT  = 7;
  localparam int SUBSYS_STAT_BIT  = 5;
  localparam int SUBSYS_SEL_BIT   = 4;
  localparam int MAIN_SRC_SEL_BIT = 0;
  localparam int MAIN_SRC_STA_BIT = 1;
  localparam int MAIN_OSC_STP_BIT = 7;
  localparam int RING_OSC_STP_BIT = 0;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic       MAIN_SRC_SEL_RST = 1'b0;
  localparam logic       MAIN_OSC_STP_RST = 1'b0;
  localparam logic [4:0] SW_RING_SWITCH   = 5'h02;
  localparam logic [4:0] SW_SUBSYS_SWITCH = 5'h10;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0]
  {
    CCM_RING   = 4'h1,
    CCM_MAIN   = 4'h2,
    CCM_SUBSYS = 4'h4,
    CCM_SWITCH = 4'h8
  } ccm_mode_e;

  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ccm_apb_req_s;

  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ccm_apb_rsp_s;

  typedef struct packed
  {
    logic main_osc_run;
    logic ring_osc_run;
    logic cpu_on_main;
    logic cpu_on_subsys;
  } ccm_clk_ctl_s;

endpackage

/* File: rtl/ccm_cpu_clock_ctrl.sv */
`timescale 1ns/1ps
module ccm_cpu_clock_ctrl
#(
  parameter bit RING_SW_STOPPABLE = 1'b1
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // register bus
  input  wire ccm_pkg::ccm_apb_req_s apb_req,
  output      ccm_pkg::ccm_apb_rsp_s apb_rsp,
  // oscillator and mux control
  output      ccm_pkg::ccm_clk_ctl_s clk_ctl
);
  import ccm_pkg::*;

  typedef struct packed
  {
    ccm_mode_e     mode;
    ccm_mode_e     target;
    logic [4:0]    wait_cnt;
    logic          subsys_halt;
    logic          subsys_sel;
    logic          main_sel;
    logic          main_stop;
    logic          ring_stop;
    logic          subsys_status;
    logic          main_status;
    ccm_apb_rsp_s  rsp;
    ccm_clk_ctl_s  ctl;
  } ccm_state_s;

  ccm_state_s state_reg;
  ccm_state_s state_next;

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_word(input ccm_state_s s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      PROCESSOR_CLOCK_CTRL_OFF:
      begin
        w[SUBSYS_HALT_BIT] = s.subsys_halt;
        w[SUBSYS_SEL_BIT]  = s.subsys_sel;
        w[SUBSYS_STAT_BIT] = s.subsys_status;   // read-only
      end
      MAIN_CLOCK_MODE_REG_OFF:
      begin
        w[MAIN_SRC_SEL_BIT] = s.main_sel;
        w[MAIN_SRC_STA_BIT] = s.main_status;    // read-only
      end
      MAIN_OSC_CTRL_OFF:     w[MAIN_OSC_STP_BIT] = s.main_stop;
      RING_OSC_MODE_REG_OFF: w[RING_OSC_STP_BIT] = s.ring_stop;
      default:               w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == PROCESSOR_CLOCK_CTRL_OFF) || (a == MAIN_CLOCK_MODE_REG_OFF) ||
           (a == MAIN_OSC_CTRL_OFF) || (a == RING_OSC_MODE_REG_OFF);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic access;
    logic done;
    logic wr;
    access     = 1'b0;
    done       = 1'b0;
    wr         = 1'b0;
    state_next = state_reg;
    // registered answer: pready high in the second cycle of every access phase
    access = apb_req.psel && apb_req.penable && !state_reg.rsp.pready;
    // the write lands at the edge that completes the transfer, where the master
    // sees pready high, so register state and bus handshake always agree
    done   = apb_req.psel && apb_req.penable && state_reg.rsp.pready;
    wr     = done && apb_req.pwrite && addr_mapped(apb_req.paddr);
    state_next.rsp.pready  = access;
    state_next.rsp.pslverr = access && !addr_mapped(apb_req.paddr);
    state_next.rsp.prdata  = (access && !apb_req.pwrite) ?
                             read_word(state_reg, apb_req.paddr) : 32'h0000_0000;

    // software writes to setting flags; status bits are not writable
    if (wr)
    begin
      case (apb_req.paddr)
        PROCESSOR_CLOCK_CTRL_OFF:
        begin
          state_next.subsys_halt = apb_req.pwdata[SUBSYS_HALT_BIT];
          state_next.subsys_sel  = apb_req.pwdata[SUBSYS_SEL_BIT];
        end
        MAIN_CLOCK_MODE_REG_OFF: state_next.main_sel  = apb_req.pwdata[MAIN_SRC_SEL_BIT];
        MAIN_OSC_CTRL_OFF:       state_next.main_stop = apb_req.pwdata[MAIN_OSC_STP_BIT];
        RING_OSC_MODE_REG_OFF:   state_next.ring_stop = apb_req.pwdata[RING_OSC_STP_BIT];
        default:                 state_next.main_sel  = state_reg.main_sel;
      endcase
    end

    // ---------------------------------------------------------------
    // mode sequencer
    // ---------------------------------------------------------------
    // old clock kept until the wait count expires; an illegal setting flag
    // stays stored and acts as soon as a later mode permits it
    case (state_reg.mode)
      CCM_RING:
      begin
        // illegal direct jump to subsystem is ignored; software must go via main
        if (state_reg.main_sel)
        begin
          state_next.mode     = CCM_SWITCH;
          state_next.target   = CCM_MAIN;
          state_next.wait_cnt = SW_RING_SWITCH;
        end
      end
      CCM_MAIN:
      begin
        if (state_reg.subsys_sel)
        begin
          state_next.mode     = CCM_SWITCH;
          state_next.target   = CCM_SUBSYS;
          state_next.wait_cnt = SW_SUBSYS_SWITCH;
        end
        else if (!state_reg.main_sel)
        begin
          state_next.mode     = CCM_SWITCH;
          state_next.target   = CCM_RING;
          state_next.wait_cnt = SW_RING_SWITCH;
        end
      end
      CCM_SUBSYS:
      begin
        // only exit is back to main; cleared main_sel is not honoured here
        if (!state_reg.subsys_sel)
        begin
          state_next.mode     = CCM_SWITCH;
          state_next.target   = CCM_MAIN;
          state_next.wait_cnt = SW_SUBSYS_SWITCH;
        end
      end
      CCM_SWITCH:
      begin
        if (state_reg.wait_cnt <= 5'h01)
          state_next.mode = state_reg.target;
        else
          state_next.wait_cnt = state_reg.wait_cnt - 5'h01;
      end
      default: state_next.mode = CCM_RING;
    endcase

    // ---------------------------------------------------------------
    // source status and oscillator control
    // ---------------------------------------------------------------
    // statuses follow the settled mux only, never the write itself; while a
    // switch is in flight the cpu still runs on the old source, so they hold
    if (state_next.mode != CCM_SWITCH)
    begin
      state_next.main_status   = (state_next.mode == CCM_MAIN) ||
                                 (state_next.mode == CCM_SUBSYS);
      state_next.subsys_status = (state_next.mode == CCM_SUBSYS);
    end
    state_next.ctl.cpu_on_main   = state_next.main_status && !state_next.subsys_status;
    state_next.ctl.cpu_on_subsys = state_next.subsys_status;

    // crystal control depends on the source actually driving the cpu
    case (state_next.mode)
      CCM_RING:   state_next.ctl.main_osc_run = !state_next.main_stop;
      CCM_SUBSYS: state_next.ctl.main_osc_run = !state_next.subsys_halt;
      default:    state_next.ctl.main_osc_run = 1'b1;
    endcase

    // ring oscillator may stop only in main or subsystem mode, never while it is the cpu clock or a switch is in flight
    state_next.ctl.ring_osc_run = !(RING_SW_STOPPABLE && state_next.ring_stop &&
                                    state_next.mode != CCM_RING &&
                                    state_next.mode != CCM_SWITCH);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg                  <= '0;
      state_reg.mode             <= CCM_RING;
      state_reg.target           <= CCM_RING;
      state_reg.main_sel         <= MAIN_SRC_SEL_RST;
      state_reg.main_stop        <= MAIN_OSC_STP_RST;
      state_reg.ctl.main_osc_run <= 1'b1;
      state_reg.ctl.ring_osc_run <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // outputs, straight from the state register
  // ---------------------------------------------------------------
  assign apb_rsp = state_reg.rsp;
  assign clk_ctl = state_reg.ctl;

endmodule

/* File: sim/ccm_cpu_clock_ctrl_monitor.sv */
`timescale 1ns/1ps
module ccm_monitor
#(
  parameter bit RING_SW_STOPPABLE = 1'b1
)
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // watched ports
  input wire ccm_pkg::ccm_apb_req_s apb_req,
  input wire ccm_pkg::ccm_apb_rsp_s apb_rsp,
  input wire ccm_pkg::ccm_clk_ctl_s clk_ctl
);
  import ccm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // cpu source decode, ring is both mux flags low
  wire on_ring = !clk_ctl.cpu_on_main && !clk_ctl.cpu_on_subsys;
  wire on_main = clk_ctl.cpu_on_main && !clk_ctl.cpu_on_subsys;
  wire wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  sequence s_go_main;
    wr_done && apb_req.paddr == MAIN_CLOCK_MODE_REG_OFF && apb_req.pwdata[MAIN_SRC_SEL_BIT]
      && on_ring && clk_ctl.main_osc_run;
  endsequence
  sequence s_go_sub;
    wr_done && apb_req.paddr == PROCESSOR_CLOCK_CTRL_OFF && apb_req.pwdata[SUBSYS_SEL_BIT]
      && on_main;
  endsequence
  sequence s_halt_sub;
    wr_done && apb_req.paddr == PROCESSOR_CLOCK_CTRL_OFF && apb_req.pwdata[SUBSYS_HALT_BIT]
      && clk_ctl.cpu_on_subsys;
  endsequence
  property p_ready_next; apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  property p_ready_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  property p_err_ready; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
  property p_rdata_idle; !apb_rsp.pready |-> apb_rsp.prdata == 32'h0; endproperty
  property p_main_keeps; on_main |-> clk_ctl.main_osc_run; endproperty
  property p_ring_runs; on_ring |-> clk_ctl.ring_osc_run; endproperty
  property p_no_option; !RING_SW_STOPPABLE |-> clk_ctl.ring_osc_run; endproperty
  property p_stop_keeps_mux; $fell(clk_ctl.ring_osc_run) || $fell(clk_ctl.main_osc_run)
    |-> $stable(clk_ctl.cpu_on_subsys) && $stable(clk_ctl.cpu_on_main); endproperty
  property p_go_main; s_go_main |=> !clk_ctl.cpu_on_main ##[1:4] clk_ctl.cpu_on_main;
  endproperty
  property p_go_sub; s_go_sub |=> !clk_ctl.cpu_on_subsys ##[12:24] clk_ctl.cpu_on_subsys;
  endproperty
  property p_halt_sub; s_halt_sub |-> ##[1:4] !clk_ctl.main_osc_run; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer to access");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  a_main_keeps: assert property (p_main_keeps) else $error("crystal stopped");
  a_ring_runs: assert property (p_ring_runs) else $error("ring stopped as cpu clock");
  a_no_option: assert property (p_no_option) else $error("ring stopped w/o option");
  a_stop_keeps_mux: assert property (p_stop_keeps_mux) else $error("mux moved");
  a_go_main: assert property (p_go_main) else $error("ring to main timing");
  a_go_sub: assert property (p_go_sub) else $error("main to subsys timing");
  a_halt_sub: assert property (p_halt_sub) else $error("halt did not stop crystal");
endmodule
bind ccm_cpu_clock_ctrl ccm_monitor #(.RING_SW_STOPPABLE(RING_SW_STOPPABLE)) u_mon
  (.clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .clk_ctl(clk_ctl));

/* File: sim/ccm_cpu_clock_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module ccm_cpu_clock_ctrl_tb;
  import ccm_pkg::*;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  ccm_apb_req_s req = '0;
  ccm_apb_rsp_s rsp;
  ccm_clk_ctl_s ctl;
  ccm_apb_rsp_s rsp_fix;
  ccm_clk_ctl_s ctl_fix;
  logic [31:0]  rd;
  logic         err;
  int           fails = 0;
  int           checks_done = 0;
  localparam logic [7:0] A_PROC = PROCESSOR_CLOCK_CTRL_OFF;
  localparam logic [7:0] A_MODE = MAIN_CLOCK_MODE_REG_OFF;
  localparam logic [7:0] A_MOSC = MAIN_OSC_CTRL_OFF;
  localparam logic [7:0] A_RING = RING_OSC_MODE_REG_OFF;
  always #2.5 clk = ~clk;
  ccm_cpu_clock_ctrl dut (.clk(clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .clk_ctl(ctl));
  // second copy without the software-stop option, fed the same bus
  ccm_cpu_clock_ctrl #(.RING_SW_STOPPABLE(1'b0)) dut_fixed (.clk(clk), .resetn(resetn),
    .apb_req(req), .apb_rsp(rsp_fix), .clk_ctl(ctl_fix));
  // one apb transfer, then a pause longer than the slowest mux switch
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    repeat (24) @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far beyond the sequence length
  initial
  begin
    #60000;
    fails++;
    tally_and_finish;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rdchk(A_MODE, 32'h0, "mode_rst");
    `CHK("ctl_rst", 4'hC, ctl)
    xfer(1'b1, A_PROC, 32'h80);
    `CHK("halt_ring", 1'b1, ctl.main_osc_run)
    xfer(1'b1, A_PROC, 32'h0);
    xfer(1'b1, A_MOSC, 32'h80);
    `CHK("stop_ring", 1'b0, ctl.main_osc_run)
    rdchk(A_MOSC, 32'h80, "mosc_rd");
    xfer(1'b1, A_MOSC, 32'h0);
    xfer(1'b1, A_PROC, 32'h10);
    `CHK("sub_from_ring", 4'hC, ctl)
    xfer(1'b1, A_PROC, 32'h0);
    $display("ring mode test done");
    xfer(1'b1, A_MODE, 32'h1);
    rdchk(A_MODE, 32'h3, "mode_main");
    rdchk(A_PROC, 32'h0, "proc_main");
    xfer(1'b1, A_PROC, 32'h80);
    xfer(1'b1, A_MOSC, 32'h80);
    `CHK("ctl_main", 4'hE, ctl)
    xfer(1'b1, A_MOSC, 32'h0);
    xfer(1'b1, A_PROC, 32'h0);
    xfer(1'b1, A_RING, 32'h1);
    `CHK("ring_stop_main", 1'b0, ctl.ring_osc_run)
    `CHK("ring_fixed", 1'b1, ctl_fix.ring_osc_run)
    xfer(1'b1, A_RING, 32'h0);
    $display("main mode test done");
    xfer(1'b1, A_PROC, 32'h10);
    rdchk(A_PROC, 32'h30, "proc_sub");
    `CHK("on_sub", 1'b1, ctl.cpu_on_subsys)
    xfer(1'b1, A_MOSC, 32'h80);
    `CHK("main_osc_stop_sub", 1'b1, ctl.main_osc_run)
    xfer(1'b1, A_MOSC, 32'h0);
    xfer(1'b1, A_RING, 32'h1);
    `CHK("ring_stop_sub", 1'b0, ctl.ring_osc_run)
    xfer(1'b1, A_PROC, 32'h90);
    `CHK("halt_sub", 1'b0, ctl.main_osc_run)
    rdchk(A_PROC, 32'hB0, "proc_halt");
    xfer(1'b1, A_MODE, 32'h0);
    rdchk(A_MODE, 32'h2, "mode_keep");
    `CHK("keep_sub", 1'b1, ctl.cpu_on_subsys)
    xfer(1'b1, A_MODE, 32'h1);
    xfer(1'b1, A_PROC, 32'h10);
    xfer(1'b1, A_RING, 32'h0);
    xfer(1'b1, A_PROC, 32'h0);
    rdchk(A_PROC, 32'h0, "proc_back");
    `CHK("ctl_back", 4'hE, ctl)
    $display("subsystem test done");
    rdchk(8'h10, 32'h0, "unmapped_rd");
    `CHK("unmapped_err", 1'b1, err)
    $display("unmapped test done");
    tally_and_finish;
  end
endmodule
